//--- rtl/cma_map.svh
// Purpose: offsets, field positions, codes and reset values
// Assumes: included by bare name
// Notes: definitions only
`ifndef CMA_MAP_SVH
`define CMA_MAP_SVH
`define CMA_OFF_ASI 3'h0
`define CMA_OFF_VA 3'h1
`define CMA_OFF_WD_LO 3'h2
`define CMA_OFF_WD_HI 3'h3
`define CMA_OFF_CMD 3'h4
`define CMA_OFF_RD_LO 3'h5
`define CMA_OFF_RD_HI 3'h6
`define CMA_OFF_STATUS 3'h7
`define CMA_CMD_STORE 0
`define CMA_CMD_PRIV 1
`define CMA_CMD_DWORD 2
`define CMA_ST_BUSY 0
`define CMA_ST_CS 1
`define CMA_ST_FMT 2
`define CMA_ASI_OTHER_LO 8'h03
`define CMA_ASI_DC_DATA 8'h0F
`define CMA_ASI_FL_LO 8'h10
`define CMA_ASI_FL_HI 8'h14
`define CMA_ASI_IFL_LO 8'h18
`define CMA_ASI_IFL_HI 8'h1C
`define CMA_ASI_PASS 8'h20
`define CMA_ASI_SC 8'h30
`define CMA_ASI_SNOOP 8'h31
`define CMA_ASI_PTD 8'h32
`define CMA_ASI_IC_FLASH 8'h36
`define CMA_ASI_DC_FLASH 8'h37
`define CMA_AGE_RST 8'hE4
`endif

//--- rtl/cma_pkg.sv
// Purpose: types of the alternate-space maintenance block
// Assumes: nothing
// Notes: constants live in cma_map.svh
package cma_pkg;
    typedef enum logic [2:0] {
        st_idle, st_exec, st_chk, st_wb, st_diag
    } cma_state_t;
    typedef struct packed {
        logic ic_inval;
        logic ic_flash;
        logic dc_inval;
        logic dc_flash;
        logic wb_req;
        logic [8:0] index;
    } cma_cache_op_t;
    typedef struct packed {
        cma_state_t st;
        logic [7:0] asi;
        logic [31:0] va;
        logic [63:0] wd;
        logic store;
        logic priv;
        logic dword;
        logic [63:0] rd;
        logic cs_err;
        logic fmt_err;
        logic [31:0] prdata;
        cma_cache_op_t op;
        logic pa_valid;
        logic pa_write;
        logic [30:0] pa_addr;
        logic diag_req;
        logic diag_sel;
        logic diag_we;
        logic [5:0] diag_tag;
        logic fsr_cs_set;
        logic [3:0][13:0] ptd_va;
        logic [3:0][23:0] ptd_pa;
        logic [3:0] ptd_v;
        logic [3:0][1:0] age;
    } cma_regs_t;
endpackage

//--- rtl/cma_top.sv
// Purpose: alternate-space cache and mmu maintenance engine, apb slave
// Assumes: cache, secondary cache and memory sides answer by handshake
// Notes: zero-wait apb; one command in flight; snoop ram held inside
`timescale 1ns/1ps
`include "cma_map.svh"
module cma_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dc_line_dirty,
    input wire logic wb_done,
    input wire logic diag_ack,
    input wire logic [63:0] diag_rdata,
    input wire logic fill_valid,
    input wire logic [8:0] fill_index,
    input wire logic [17:0] fill_tag,
    input wire logic snoop_enable_bit,
    input wire logic debug_mode,
    output cma_pkg::cma_cache_op_t cache_op,
    output logic pa_valid,
    output logic pa_write,
    output logic [30:0] pa_addr,
    output logic diag_req,
    output logic diag_sel,
    output logic diag_we,
    output logic [31:0] diag_addr,
    output logic [63:0] diag_wdata,
    output logic [5:0] diag_tag,
    output logic fsr_cs_set
);
    cma_pkg::cma_regs_t r;
    cma_pkg::cma_regs_t next_r;
    logic [18:0] snoop_mem [0:511];
    logic [8:0] snp_idx;
    logic [18:0] snp_rd;
    logic [31:0] snp_word;
    logic apb_wr;
    logic unmapped;
    logic unassigned;
    logic [8:0] line_idx;
    logic [1:0] lru_i;
    logic [1:0] hit_i;
    logic ptd_hit;
    logic [31:0] rd_mux;

    function automatic logic [3:0][1:0] touch(input logic [3:0][1:0] a,
                                              input logic [1:0] k);
        logic [3:0][1:0] t;
        t = a;
        for (int j = 0; j < 4; j++) begin
            if (a[j] < a[k]) begin
                t[j] = a[j] + 2'h1;
            end
        end
        t[k] = 2'h0;
        return t;
    endfunction

    assign unmapped = (paddr[31:5] != 27'h0);
    assign apb_wr = psel && penable && pwrite && !unmapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && unmapped;
    assign line_idx = r.va[13:5];
    assign snp_idx = {r.va[3:2], r.va[11:5]};
    assign snp_rd = snoop_mem[snp_idx];
    assign snp_word = {snp_rd[18:1], snp_idx, snp_rd[0],
                       snp_rd[18:1] == r.va[29:12], 3'h0};
    assign unassigned = !((r.asi >= `CMA_ASI_OTHER_LO &&
                           r.asi <= `CMA_ASI_FL_HI) ||
                          (r.asi >= `CMA_ASI_IFL_LO &&
                           r.asi <= `CMA_ASI_IFL_HI) ||
                          r.asi == `CMA_ASI_PASS ||
                          (r.asi >= `CMA_ASI_SC &&
                           r.asi <= `CMA_ASI_PTD) ||
                          r.asi == `CMA_ASI_IC_FLASH ||
                          r.asi == `CMA_ASI_DC_FLASH);

    // descriptor lookup and replacement choice
    always_comb begin
        lru_i = 2'h0;
        hit_i = 2'h0;
        ptd_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (r.age[i] == 2'h3) begin
                lru_i = 2'(i);
            end
            if (r.ptd_v[i] && r.ptd_va[i] == r.va[31:18]) begin
                hit_i = 2'(i);
                ptd_hit = 1'b1;
            end
        end
    end

    always_comb begin
        case (paddr[4:2])
            `CMA_OFF_ASI: rd_mux = {24'h0, r.asi};
            `CMA_OFF_VA: rd_mux = r.va;
            `CMA_OFF_WD_LO: rd_mux = r.wd[31:0];
            `CMA_OFF_WD_HI: rd_mux = r.wd[63:32];
            `CMA_OFF_CMD: rd_mux = {29'h0, r.dword, r.priv, r.store};
            `CMA_OFF_RD_LO: rd_mux = r.rd[31:0];
            `CMA_OFF_RD_HI: rd_mux = r.rd[63:32];
            default: rd_mux = {29'h0, r.fmt_err, r.cs_err,
                               r.st != cma_pkg::st_idle};
        endcase
        if (unmapped) begin
            rd_mux = 32'h0;
        end
    end

    always_comb begin
        next_r = r;
        next_r.op.ic_inval = 1'b0;
        next_r.op.ic_flash = 1'b0;
        next_r.op.dc_inval = 1'b0;
        next_r.op.dc_flash = 1'b0;
        next_r.pa_valid = 1'b0;
        next_r.fsr_cs_set = 1'b0;
        if (psel && !penable) begin
            next_r.prdata = rd_mux;
        end
        if (apb_wr && r.st == cma_pkg::st_idle) begin
            case (paddr[4:2])
                `CMA_OFF_ASI: next_r.asi = pwdata[7:0];
                `CMA_OFF_VA: next_r.va = pwdata;
                `CMA_OFF_WD_LO: next_r.wd[31:0] = pwdata;
                `CMA_OFF_WD_HI: next_r.wd[63:32] = pwdata;
                `CMA_OFF_CMD: begin
                    next_r.store = pwdata[`CMA_CMD_STORE];
                    next_r.priv = pwdata[`CMA_CMD_PRIV];
                    next_r.dword = pwdata[`CMA_CMD_DWORD];
                    next_r.st = cma_pkg::st_exec;
                end
                default: ;
            endcase
        end
        if (apb_wr && paddr[4:2] == `CMA_OFF_STATUS) begin
            if (pwdata[`CMA_ST_CS]) next_r.cs_err = 1'b0;
            if (pwdata[`CMA_ST_FMT]) next_r.fmt_err = 1'b0;
        end
        case (r.st)
            cma_pkg::st_idle: ;
            cma_pkg::st_exec: begin
                next_r.st = cma_pkg::st_idle;
                if (!r.store) next_r.rd = 64'h0;
                if (unassigned) begin
                    next_r.cs_err = 1'b1;
                    next_r.fsr_cs_set = 1'b1;
                end else if (r.asi >= `CMA_ASI_FL_LO &&
                             r.asi <= `CMA_ASI_FL_HI) begin
                    if (r.store) begin
                        next_r.op.index = line_idx;
                        next_r.op.ic_inval = 1'b1;
                        next_r.st = cma_pkg::st_chk;
                    end
                end else if (r.asi >= `CMA_ASI_IFL_LO &&
                             r.asi <= `CMA_ASI_IFL_HI) begin
                    if (r.store) begin
                        next_r.op.index = line_idx;
                        next_r.op.ic_inval = 1'b1;
                    end
                end else if (r.asi == `CMA_ASI_PASS) begin
                    if (r.priv) begin
                        next_r.pa_valid = 1'b1;
                        next_r.pa_write = r.store;
                        next_r.pa_addr = r.va[30:0];
                    end else begin
                        next_r.fmt_err = 1'b1;
                    end
                end else if (r.asi == `CMA_ASI_SC) begin
                    if (r.dword) begin
                        next_r.diag_req = 1'b1;
                        next_r.diag_sel = 1'b1;
                        next_r.diag_we = r.store;
                        next_r.diag_tag = r.va[29:24];
                        next_r.st = cma_pkg::st_diag;
                    end else begin
                        next_r.fmt_err = 1'b1;
                    end
                end else if (r.asi == `CMA_ASI_DC_DATA) begin
                    if (r.va[31:14] == 18'h0) begin
                        next_r.diag_req = 1'b1;
                        next_r.diag_sel = 1'b0;
                        next_r.diag_we = r.store;
                        next_r.st = cma_pkg::st_diag;
                    end else begin
                        next_r.fmt_err = 1'b1;
                    end
                end else if (r.asi == `CMA_ASI_SNOOP) begin
                    if (!r.store) next_r.rd = {32'h0, snp_word};
                end else if (r.asi == `CMA_ASI_PTD) begin
                    if (r.store) begin
                        next_r.ptd_va[lru_i] = r.va[31:18];
                        next_r.ptd_pa[lru_i] = r.wd[27:4];
                        next_r.ptd_v[lru_i] = 1'b1;
                        next_r.age = touch(r.age, lru_i);
                    end else if (ptd_hit) begin
                        next_r.rd[27:4] = r.ptd_pa[hit_i];
                        next_r.age = touch(r.age, hit_i);
                    end
                end else if (r.asi == `CMA_ASI_IC_FLASH) begin
                    if (r.store) next_r.op.ic_flash = 1'b1;
                end else if (r.asi == `CMA_ASI_DC_FLASH) begin
                    if (r.store) next_r.op.dc_flash = 1'b1;
                end
            end
            cma_pkg::st_chk: begin
                if (dc_line_dirty) begin
                    next_r.op.wb_req = 1'b1;
                    next_r.st = cma_pkg::st_wb;
                end else begin
                    next_r.op.dc_inval = 1'b1;
                    next_r.st = cma_pkg::st_idle;
                end
            end
            cma_pkg::st_wb: begin
                if (wb_done) begin
                    next_r.op.wb_req = 1'b0;
                    next_r.op.dc_inval = 1'b1;
                    next_r.st = cma_pkg::st_idle;
                end
            end
            cma_pkg::st_diag: begin
                if (diag_ack) begin
                    next_r.diag_req = 1'b0;
                    next_r.st = cma_pkg::st_idle;
                    if (!r.diag_we) begin
                        next_r.rd = (r.diag_sel && r.va[31]) ?
                            {56'h0, diag_rdata[7:0]} : diag_rdata;
                    end
                end
            end
            default: next_r.st = cma_pkg::st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= cma_pkg::st_idle;
            r.age <= `CMA_AGE_RST;
        end else begin
            r <= next_r;
        end
    end

    // snoop ram: software access wins over a same-cycle fill
    always_ff @(posedge pclk) begin
        if (r.st == cma_pkg::st_exec && r.asi == `CMA_ASI_SNOOP &&
            r.store) begin
            snoop_mem[snp_idx] <= {r.va[29:12], r.va[4]};
        end else if (fill_valid && (debug_mode || snoop_enable_bit)) begin
            snoop_mem[fill_index] <= {fill_tag, 1'b1};
        end
    end

    assign prdata = r.prdata;
    assign cache_op = r.op;
    assign pa_valid = r.pa_valid;
    assign pa_write = r.pa_write;
    assign pa_addr = r.pa_addr;
    assign diag_req = r.diag_req;
    assign diag_sel = r.diag_sel;
    assign diag_we = r.diag_we;
    assign diag_addr = r.va;
    assign diag_wdata = r.wd;
    assign diag_tag = r.diag_tag;
    assign fsr_cs_set = r.fsr_cs_set;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic ex;
    assign ex = r.st == cma_pkg::st_exec;

    AST_FLUSH_BOTH: assert property (ex && r.store &&
        r.asi >= 8'h10 && r.asi <= 8'h14 |=> cache_op.ic_inval &&
        r.st == cma_pkg::st_chk && cache_op.index == $past(r.va[13:5]))
        else $error("combined flush did not invalidate icache line");
    AST_DIRTY_WB: assert property (r.st == cma_pkg::st_chk &&
        dc_line_dirty |=> cache_op.wb_req && !cache_op.dc_inval)
        else $error("dirty line not written back before invalidate");
    AST_CLEAN_INV: assert property (r.st == cma_pkg::st_chk &&
        !dc_line_dirty |=> cache_op.dc_inval && !cache_op.wb_req)
        else $error("clean line not invalidated at once");
    AST_IC_ONLY: assert property (ex && r.store &&
        r.asi >= 8'h18 && r.asi <= 8'h1C |=> cache_op.ic_inval ##1
        !cache_op.dc_inval && !cache_op.wb_req)
        else $error("icache-only flush touched data cache");
    AST_PASS: assert property (ex && r.priv && r.asi == 8'h20 |=>
        pa_valid && pa_addr == $past(r.va[30:0]))
        else $error("pass-through address not driven");
    AST_SC_DWORD: assert property (ex && r.asi == 8'h30 &&
        !r.dword |=> !diag_req && r.fmt_err)
        else $error("non-doubleword secondary cache access issued");
    AST_SC_TAG: assert property (diag_req && diag_sel && diag_we |->
        diag_tag == diag_addr[29:24])
        else $error("secondary cache tag not from address");
    AST_DD_IDX: assert property (diag_req && !diag_sel |->
        diag_addr[31:14] == 18'h0)
        else $error("data cache access with upper bits set");
    AST_SNOOP_RD: assert property (ex && !r.store &&
        r.asi == 8'h31 |=> r.rd[2:0] == 3'h0 &&
        r.rd[13:5] == {r.va[3:2], r.va[11:5]})
        else $error("snoop read word malformed");
    AST_FLASH: assert property (ex && r.store &&
        r.asi == 8'h37 |=> cache_op.dc_flash && !cache_op.wb_req &&
        !cache_op.ic_flash)
        else $error("data flash clear wrong");
    AST_CS: assert property (ex && unassigned |=> fsr_cs_set &&
        r.cs_err ##1 !fsr_cs_set)
        else $error("unassigned space not flagged");
    AST_LOAD_WO: assert property (ex && !r.store &&
        (r.asi == 8'h36 || r.asi == 8'h37 ||
        (r.asi >= 8'h10 && r.asi <= 8'h14)) |=> !cache_op.ic_inval &&
        !cache_op.ic_flash && !cache_op.dc_flash &&
        r.st == cma_pkg::st_idle)
        else $error("load to write-only space changed cache");
    AST_IC_FLASH: assert property (ex && r.store &&
        r.asi == 8'h36 |=> cache_op.ic_flash && !cache_op.dc_flash &&
        !cache_op.ic_inval)
        else $error("instruction flash clear wrong");
    AST_PTD_WR: assert property (ex && r.store &&
        r.asi == 8'h32 |=> r.ptd_va[$past(lru_i)] == $past(r.va[31:18]) &&
        r.ptd_pa[$past(lru_i)] == $past(r.wd[27:4]) &&
        r.age[$past(lru_i)] == 2'h0)
        else $error("descriptor write missed the oldest entry");
    AST_SNOOP_WR: assert property (ex && r.store &&
        r.asi == 8'h31 |=> snoop_mem[$past({r.va[3:2], r.va[11:5]})] ==
        $past({r.va[29:12], r.va[4]}))
        else $error("snoop write not taken from address");
    AST_FILL: assert property (fill_valid && debug_mode &&
        !(ex && r.store && r.asi == 8'h31) |=>
        snoop_mem[$past(fill_index)] == {$past(fill_tag), 1'b1})
        else $error("debug fill did not update snoop memory");
    AST_SC_TAG_RD: assert property (r.st == cma_pkg::st_diag &&
        diag_ack && r.diag_sel && !r.diag_we && r.va[31] |=>
        r.rd == {56'h0, $past(diag_rdata[7:0])})
        else $error("secondary cache tag read not on low byte");

    COV_WB: cover property (r.st == cma_pkg::st_wb ##[1:20] cache_op.dc_inval);
    COV_SC_RD: cover property (diag_req && diag_sel && !diag_we ##1 diag_ack);
    COV_PTD_HIT: cover property (ex && r.asi == 8'h32 && !r.store && ptd_hit);
    COV_DIRTY: cover property (r.st == cma_pkg::st_chk && dc_line_dirty);
    COV_FILL: cover property (fill_valid && debug_mode && !snoop_enable_bit);
endmodule // cma_top

//--- sim/cma_far_model.sv
// Purpose: far side of the maintenance block: dcache, memory, secondary cache
// Assumes: requests are held until answered
// Notes: answers lag+1 cycles after a request is seen; idle read data toggles
`timescale 1ns/1ps
module cma_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dirty_cfg,
    input wire logic [3:0] lag,
    input wire logic wb_req,
    input wire logic diag_req,
    input wire logic diag_we,
    input wire logic [63:0] diag_wdata,
    output logic dc_line_dirty,
    output logic wb_done,
    output logic diag_ack,
    output logic [63:0] diag_rdata
);
    logic [63:0] mem;
    logic [3:0] cnt;
    assign dc_line_dirty = dirty_cfg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            wb_done <= 1'b0;
            diag_ack <= 1'b0;
            diag_rdata <= 64'h0;
            mem <= 64'h0;
        end else begin
            wb_done <= 1'b0;
            diag_ack <= 1'b0;
            diag_rdata <= ~diag_rdata;
            if ((wb_req && !wb_done) || (diag_req && !diag_ack)) begin
                cnt <= cnt + 4'h1;
                if (cnt == lag) begin
                    cnt <= 4'h0;
                    wb_done <= wb_req;
                    diag_ack <= diag_req;
                    if (diag_req && diag_we) mem <= diag_wdata;
                    diag_rdata <= mem;
                end
            end
        end
    end
endmodule // cma_far_model

//--- sim/tb.sv
// Purpose: self-checking bench of the maintenance block
// Assumes: zero-wait apb, far side model
// Notes: side outputs watched on the falling edge; apb read data taken at the rising edge
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [31:0] paddr, pwdata, prdata, diag_addr, rdat, st, m_da;
    logic dc_line_dirty, wb_done, diag_ack, fill_valid, snoop_enable_bit;
    logic debug_mode, pa_valid, pa_write, diag_req, diag_sel, diag_we;
    logic fsr_cs_set, dirty_cfg, m_sel, m_we, m_pw;
    logic [63:0] diag_rdata, diag_wdata, rd, m_wd;
    logic [8:0] fill_index, m_idx;
    logic [17:0] fill_tag;
    logic [30:0] pa_addr, m_pa;
    logic [5:0] diag_tag, m_tag;
    logic [3:0] lag;
    cma_pkg::cma_cache_op_t cache_op;
    int n_errors, total_checks, n_ic, n_dc, n_icf, n_dcf, n_pa, n_cs, n_wb;
    int n_dw, n_dg;
    cma_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .dc_line_dirty, .wb_done, .diag_ack,
        .diag_rdata, .fill_valid, .fill_index, .fill_tag, .snoop_enable_bit,
        .debug_mode, .cache_op, .pa_valid, .pa_write, .pa_addr, .diag_req,
        .diag_sel, .diag_we, .diag_addr, .diag_wdata, .diag_tag, .fsr_cs_set);
    cma_far_model far (.pclk, .presetn, .dirty_cfg, .lag,
        .wb_req(cache_op.wb_req), .diag_req, .diag_we, .diag_wdata,
        .dc_line_dirty, .wb_done, .diag_ack, .diag_rdata);
    always @(negedge pclk) begin
        n_ic += int'(cache_op.ic_inval === 1'b1);
        n_dc += int'(cache_op.dc_inval === 1'b1);
        n_icf += int'(cache_op.ic_flash === 1'b1);
        n_dcf += int'(cache_op.dc_flash === 1'b1);
        n_wb += int'(cache_op.wb_req === 1'b1);
        n_dw += int'(cache_op.dc_inval === 1'b1 && cache_op.wb_req !== 1'b0);
        n_cs += int'(fsr_cs_set === 1'b1);
        n_pa += int'(pa_valid === 1'b1);
        n_dg += int'(diag_req === 1'b1);
        if (cache_op.ic_inval === 1'b1) m_idx = cache_op.index;
        if (pa_valid === 1'b1) begin
            m_pa = pa_addr;
            m_pw = pa_write;
        end
        if (diag_req === 1'b1) begin
            m_tag = diag_tag;
            m_da = diag_addr;
            m_wd = diag_wdata;
            m_sel = diag_sel;
            m_we = diag_we;
        end
    end
    task automatic chk(input string nm, input logic [63:0] e,
            input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] asi, input logic [31:0] va,
            input logic [63:0] wd, input logic [2:0] c);
        apb(1'b1, 32'h0, {24'h0, asi});
        apb(1'b1, 32'h4, va);
        apb(1'b1, 32'h8, wd[31:0]);
        apb(1'b1, 32'hC, wd[63:32]);
        {n_ic, n_dc, n_icf, n_dcf, n_wb, n_dw, n_cs, n_pa, n_dg} = '0;
        apb(1'b1, 32'h10, {29'h0, c});
        rdat = 32'h1;
        while (rdat[0] === 1'b1) apb(1'b0, 32'h1C, 32'h0);
        repeat (3) @(posedge pclk);
        apb(1'b0, 32'h1C, 32'h0);
        st = rdat;
        apb(1'b0, 32'h14, 32'h0);
        rd[31:0] = rdat;
        apb(1'b0, 32'h18, 32'h0);
        rd[63:32] = rdat;
        apb(1'b1, 32'h1C, 32'h6);
    endtask
    task automatic t_flush();
        logic [8:0] ix;
        for (int i = 0; i < 2; i++) begin
            ix = i[0] ? 9'h1FF : 9'h000;
            cmd(8'h10 + 8'(4 * i), {18'h3FFFF, ix, 5'h1F}, 64'h0, 3'h1);
            chk("ic", 64'h1, 64'(n_ic));
            chk("dc", 64'h1, 64'(n_dc));
            chk("idx", 64'(ix), 64'(m_idx));
            chk("wb", 64'h0, 64'(n_wb));
        end
        dirty_cfg <= 1'b1;
        lag <= 4'h3;
        cmd(8'h12, 32'h0000_0AA0, 64'h0, 3'h1);
        chk("wb", 64'h1, 64'(n_wb > 0));
        chk("dc", 64'h1, 64'(n_dc));
        chk("dcwb", 64'h0, 64'(n_dw));
        cmd(8'h11, 32'h0, 64'h0, 3'h0);
        chk("ld", 64'h0, 64'(n_ic + n_dc + n_wb));
        dirty_cfg <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            cmd(8'h18 + 8'(4 * i), 32'hFFFF_FFE0, 64'h0, 3'h1);
            chk("ic", 64'h1, 64'(n_ic));
            chk("dc", 64'h0, 64'(n_dc + n_wb));
            chk("idx", 64'h1FF, 64'(m_idx));
        end
    endtask
    task automatic t_pass();
        for (int c = 2; c < 4; c++) begin
            cmd(8'h20, 32'hDEAD_BEEF, 64'h0, 3'(c));
            chk("pa", 64'h1, 64'(n_pa));
            chk("paddr", 64'h5EAD_BEEF, 64'(m_pa));
            chk("pw", 64'(c[0]), 64'(m_pw));
        end
        cmd(8'h20, 32'h1234_5678, 64'h0, 3'h1);
        chk("pa", 64'h0, 64'(n_pa));
        chk("fmt", 64'h1, 64'(st[2]));
    endtask
    task automatic t_diag();
        lag <= 4'h2;
        cmd(8'h30, 32'h2B00_0000, 64'h0123_4567_89AB_CDEF, 3'h5);
        chk("tag", 64'h2B, 64'(m_tag));
        chk("wd", 64'h0123_4567_89AB_CDEF, m_wd);
        chk("sel", 64'h3, 64'({m_sel, m_we}));
        chk("da", 64'h2B00_0000, 64'(m_da));
        cmd(8'h30, 32'h0, 64'h0, 3'h4);
        chk("scd", 64'h0123_4567_89AB_CDEF, rd);
        cmd(8'h30, 32'h8000_0000, 64'h0, 3'h4);
        chk("sct", 64'hEF, rd);
        cmd(8'h30, 32'h0, 64'h0, 3'h1);
        chk("scw", 64'h3, 64'({n_dg == 0, st[2]}));
        cmd(8'h0F, 32'h0000_4000, 64'h0, 3'h4);
        chk("dcb", 64'h3, 64'({n_dg == 0, st[2]}));
        cmd(8'h0F, 32'h0000_3FF8, 64'h5, 3'h5);
        chk("dcd", 64'h2, 64'({n_dg > 0, m_sel}));
        chk("dca", 64'h3FF8, 64'(m_da));
    endtask
    task automatic t_snoop();
        logic [31:0] va;
        va = {2'b00, 18'h2A5C3, 7'h27, 1'b1, 2'b11, 2'b00};
        cmd(8'h31, va, 64'hFFFF_FFFF_FFFF_FFFF, 3'h1);
        cmd(8'h31, va, 64'h0, 3'h0);
        chk("snp", {32'h0, 18'h2A5C3, 9'h1A7, 5'h18}, rd);
        cmd(8'h31, va ^ 32'h1000, 64'h0, 3'h0);
        chk("miss", {32'h0, 18'h2A5C3, 9'h1A7, 5'h10}, rd);
        debug_mode <= 1'b1;
        fill_valid <= 1'b1;
        fill_index <= 9'h0C3;
        fill_tag <= 18'h15A5A;
        @(posedge pclk);
        fill_valid <= 1'b0;
        va = {2'b00, 18'h15A5A, 7'h43, 1'b0, 2'b01, 2'b00};
        cmd(8'h31, va, 64'h0, 3'h0);
        chk("fill", {32'h0, 18'h15A5A, 9'h0C3, 5'h18}, rd);
    endtask
    task automatic t_ptd();
        for (int i = 0; i < 5; i++)
            cmd(8'h32, {14'h1000 + 14'(i), 18'h0},
                {36'h0, 24'hA00000 + 24'(i), 4'h0}, 3'h1);
        for (int i = 4; i >= 0; i--) begin
            cmd(8'h32, {14'h1000 + 14'(i), 18'h0}, 64'h0, 3'h0);
            chk("ptd", (i == 0) ? 64'h0 :
                {36'h0, 24'hA00000 + 24'(i), 4'h0}, rd);
        end
    endtask
    task automatic t_flash();
        dirty_cfg <= 1'b1;
        cmd(8'h36, 32'h0, 64'h0, 3'h1);
        chk("icf", 64'h1, 64'(n_icf));
        chk("icf_dc", 64'h0, 64'(n_dcf));
        cmd(8'h37, 32'h0, 64'h0, 3'h1);
        chk("dcf", 64'h1, 64'(n_dcf));
        chk("dcf_o", 64'h0, 64'(n_wb + n_icf));
        cmd(8'h36, 32'h0, 64'h0, 3'h0);
        chk("fld", 64'h0, 64'(n_icf + n_dcf + n_wb));
        cmd(8'h37, 32'h0, 64'h0, 3'h0);
        chk("fld", 64'h0, 64'(n_icf + n_dcf + n_wb));
    endtask
    task automatic t_unas();
        logic [7:0] tbl [6];
        tbl = '{8'h02, 8'h15, 8'h1D, 8'h21, 8'h33, 8'hFF};
        foreach (tbl[i]) begin
            cmd(tbl[i], 32'h0, 64'h0, 3'(i[0]));
            chk("cs", 64'h3, 64'({n_cs, st[1]}));
        end
        apb(1'b0, 32'h20, 32'h0);
        chk("unmap", 64'h1, 64'({rdat, rerr}));
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        n_errors++;
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite, fill_valid, debug_mode} = '0;
        {snoop_enable_bit, dirty_cfg, paddr, pwdata, fill_index} = '0;
        fill_tag = '0;
        lag = 4'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_flush();
        t_pass();
        t_diag();
        t_snoop();
        t_ptd();
        t_flash();
        t_unas();
        wrap_up();
    end
endmodule // tb
